// *** hdl/gsc_pkg.sv ***
// Constants for the three-pin set/clear GPIO port and its serial access.
// Assumes one 250 MHz clock; all widths fixed, no overrides expected.
package gsc_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADR_DIR_SET = 8'h14;
  localparam logic [7:0] ADR_DIR_CLR = 8'h15;
  localparam logic [7:0] ADR_LVL_SET = 8'h16;
  localparam logic [7:0] ADR_LVL_CLR = 8'h17;
  localparam logic [7:0] ADR_INPUT = 8'h18;
  localparam logic [7:0] ADR_LAT_SET = 8'h1A;
  localparam logic [7:0] ADR_LAT_CLR = 8'h1B;
  localparam logic [7:0] ADR_FALL_SET = 8'h1C;
  localparam logic [7:0] ADR_FALL_CLR = 8'h1D;
  localparam logic [7:0] ADR_RISE_SET = 8'h1E;
  localparam logic [7:0] ADR_RISE_CLR = 8'h1F;

  // ------------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------------
  localparam int PIN_W = 3; // Pins live in bits 0..2
  localparam logic [PIN_W-1:0] RST_PINS = 3'h0; // All regs clear
  localparam logic [4:0] PAD_ZERO = 5'h00; // Unused bits 3..7

  // ------------------------------------------------------------------
  // Serial engine constants
  // ------------------------------------------------------------------
  // Arbitrary 7-bit device address, not tied to any part
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX = 4'h7;

  // Serial engine states, one-hot
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RX = 5'b00010,
    S_ACK = 5'b00100,
    S_TX = 5'b01000,
    S_TACK = 5'b10000
  } gsc_st_t;

  // Which byte of a write transfer is being received
  typedef enum logic [2:0] {
    P_ADDR = 3'b001,
    P_PTR = 3'b010,
    P_DATA = 3'b100
  } gsc_ph_t;

endpackage

// *** hdl/gsc_reg_if.sv ***
// Internal register access path between serial engine and register file.
// Assumes both ends share CLK_I; wr is a one-cycle strobe.
`timescale 1ns/1ps

interface gsc_reg_if;
  logic [7:0] addr; // Register pointer, also read address
  logic [7:0] wdata; // Write byte
  logic wr; // One-cycle write strobe
  logic [7:0] rdata; // Combinational read of addr

  // Serial engine end
  modport eng (output addr, output wdata, output wr, input rdata);
  // Register file end
  modport regs (input addr, input wdata, input wr, output rdata);
endinterface

// *** hdl/gsc_i2c_eng.sv ***
// Two-wire serial slave that turns bus transfers into register accesses.
// Assumes SCL/SDA already synchronous and slow against the 250 MHz clock.
`timescale 1ns/1ps

module gsc_i2c_eng
  import gsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oen_o,
  // Register path
  gsc_reg_if.eng bus
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    gsc_st_t st; // Bus phase
    gsc_ph_t ph; // Byte role in a write
    logic scl_q; // Previous clock level
    logic sda_q; // Previous data level
    logic [3:0] cnt; // Bits in current byte
    logic [7:0] sh; // Shift register
    logic rnw; // Transfer is a read
    logic [7:0] ptr; // Auto-incrementing pointer
    logic oen; // Low pulls SDA low
    logic wr; // Write strobe
    logic [7:0] wd; // Write data
  } gsc_eng_t;

  gsc_eng_t s_reg, s_next;
  logic rise, fall, start, stop;

  assign rise = scl_i & ~s_reg.scl_q;
  assign fall = ~scl_i & s_reg.scl_q;
  // Data moving while the clock is high frames a transfer
  assign start = scl_i & s_reg.scl_q & s_reg.sda_q & ~sda_i;
  assign stop = scl_i & s_reg.scl_q & ~s_reg.sda_q & sda_i;

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.scl_q = scl_i;
    s_next.sda_q = sda_i;
    s_next.wr = 1'b0;
    if (start) begin
      // Repeated start is accepted anywhere
      s_next.st = S_RX;
      s_next.ph = P_ADDR;
      s_next.cnt = 4'h0;
      s_next.oen = 1'b1;
    end else if (stop) begin
      s_next.st = S_IDLE;
      s_next.oen = 1'b1;
    end else begin
      unique case (s_reg.st)
        S_IDLE: begin
          s_next.oen = 1'b1;
        end
        S_RX: begin
          // Sample on rise, act after the eighth bit's falling edge
          if (rise) begin
            s_next.sh = {s_reg.sh[6:0], sda_i};
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (fall && s_reg.cnt == BITS_BYTE) begin
            s_next.cnt = 4'h0;
            s_next.oen = 1'b0;
            s_next.st = S_ACK;
            unique case (s_reg.ph)
              P_ADDR: begin
                s_next.rnw = s_reg.sh[0];
                // Foreign address: stay silent until next start
                if (s_reg.sh[7:1] != DEV_ADDR) begin
                  s_next.oen = 1'b1;
                  s_next.st = S_IDLE;
                end
              end
              P_PTR: s_next.ptr = s_reg.sh;
              P_DATA: begin
                s_next.wr = 1'b1;
                s_next.wd = s_reg.sh;
              end
              default: s_next.st = S_IDLE;
            endcase
          end
        end
        S_ACK: begin
          // Release acknowledge on the falling edge
          if (fall) begin
            s_next.oen = 1'b1;
            s_next.st = S_RX;
            if (s_reg.ph == P_ADDR && s_reg.rnw) begin
              s_next.sh = bus.rdata;
              s_next.oen = bus.rdata[7];
              s_next.ptr = s_reg.ptr + 8'h01;
              s_next.st = S_TX;
            end else if (s_reg.ph == P_ADDR) begin
              s_next.ph = P_PTR;
            end else if (s_reg.ph == P_PTR) begin
              s_next.ph = P_DATA;
            end else begin
              s_next.ptr = s_reg.ptr + 8'h01;
            end
          end
        end
        S_TX: begin
          // Shift out MSB first, one bit per falling edge
          if (fall) begin
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == LAST_TX) begin
              s_next.oen = 1'b1;
              s_next.st = S_TACK;
            end else begin
              s_next.sh = {s_reg.sh[6:0], 1'b0};
              s_next.oen = s_reg.sh[6];
            end
          end
        end
        S_TACK: begin
          // Master NACK ends the read
          if (rise && sda_i) begin
            s_next.st = S_IDLE;
          end else if (fall) begin
            s_next.sh = bus.rdata;
            s_next.oen = bus.rdata[7];
            s_next.ptr = s_reg.ptr + 8'h01;
            s_next.cnt = 4'h0;
            s_next.st = S_TX;
          end
        end
        default: s_next.st = S_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '{st: S_IDLE, ph: P_ADDR, scl_q: 1'b1, sda_q: 1'b1,
                 cnt: 4'h0, sh: 8'h00, rnw: 1'b0, ptr: 8'h00,
                 oen: 1'b1, wr: 1'b0, wd: 8'h00};
    end else begin
      s_reg <= s_next;
    end
  end

  // Write address is the pointer before its post-write increment
  assign bus.addr = s_reg.ptr;
  assign bus.wdata = s_reg.wd;
  assign bus.wr = s_reg.wr;
  assign sda_oen_o = s_reg.oen;

endmodule

// *** hdl/gsc_gpio_port.sv ***
// Top of the three-pin GPIO port with set/clear register pairs.
// Assumes pin and serial inputs synchronous to CLK_I; pads resolved outside.
`timescale 1ns/1ps

module gsc_gpio_port
  import gsc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Serial controller pins, SDA open drain
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OEN_O,
  // GPIO pads
  input wire logic [PIN_W-1:0] GPIO_I,
  output logic [PIN_W-1:0] GPIO_O,
  output logic [PIN_W-1:0] GPIO_OEN_O,
  // Interrupt, active high
  output logic IRQ_O
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [PIN_W-1:0] dir; // 1 = output
    logic [PIN_W-1:0] lvl; // Output levels
    logic [PIN_W-1:0] lat; // Interrupt latch
    logic [PIN_W-1:0] fmask; // Falling edge enables
    logic [PIN_W-1:0] rmask; // Rising edge enables
    logic [PIN_W-1:0] prev; // Pin levels last cycle
    logic prev_ok; // prev holds a real sample
    logic [PIN_W-1:0] oen; // Pad enables, low drives
    logic irq; // Interrupt output
  } gsc_regs_t;

  gsc_regs_t st_reg, st_next;
  gsc_reg_if bus ();
  logic [PIN_W-1:0] rise_ev, fall_ev;

  // ------------------------------------------------------------------
  // Serial engine
  // ------------------------------------------------------------------
  gsc_i2c_eng u_eng (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .sda_oen_o(SDA_OEN_O),
    .bus(bus)
  );

  // Open drain: the pad only ever pulls low
  assign SDA_O = 1'b0;

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  // Apply a set or clear write to one register pair
  function automatic logic [PIN_W-1:0] sc_write(
    input logic [PIN_W-1:0] cur,
    input logic wr,
    input logic [7:0] adr,
    input logic [7:0] set_adr,
    input logic [7:0] clr_adr,
    input logic [PIN_W-1:0] d
  );
    logic [PIN_W-1:0] r;
    r = cur;
    if (wr && adr == set_adr) begin
      r = cur | d;
    end else if (wr && adr == clr_adr) begin
      r = cur & ~d;
    end
    return r;
  endfunction

  // Either address of a pair hits the same register
  function automatic logic pair_hit(
    input logic [7:0] adr,
    input logic [7:0] set_adr
  );
    return adr[7:1] == set_adr[7:1];
  endfunction

  // ------------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------------
  // First sample after reset is not compared, to avoid a false edge
  assign rise_ev = st_reg.prev_ok ? (GPIO_I & ~st_reg.prev) : RST_PINS;
  assign fall_ev = st_reg.prev_ok ? (~GPIO_I & st_reg.prev) : RST_PINS;

  // ------------------------------------------------------------------
  // Register file next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [PIN_W-1:0] d;
    logic [PIN_W-1:0] hw_set;
    d = bus.wdata[PIN_W-1:0]; // Upper data bits have no pin
    hw_set = (rise_ev & st_reg.rmask) |
             (fall_ev & st_reg.fmask);
    st_next = st_reg;
    st_next.dir = sc_write(st_reg.dir, bus.wr, bus.addr,
                           ADR_DIR_SET, ADR_DIR_CLR, d);
    st_next.lvl = sc_write(st_reg.lvl, bus.wr, bus.addr,
                           ADR_LVL_SET, ADR_LVL_CLR, d);
    st_next.fmask = sc_write(st_reg.fmask, bus.wr, bus.addr,
                             ADR_FALL_SET, ADR_FALL_CLR, d);
    st_next.rmask = sc_write(st_reg.rmask, bus.wr, bus.addr,
                             ADR_RISE_SET, ADR_RISE_CLR, d);
    // Hardware set wins over a clear in the same cycle
    st_next.lat = sc_write(st_reg.lat, bus.wr, bus.addr,
                           ADR_LAT_SET, ADR_LAT_CLR, d) | hw_set;
    st_next.prev = GPIO_I;
    st_next.prev_ok = 1'b1;
    st_next.oen = ~st_next.dir;
    st_next.irq = |st_next.lat;
  end

  // State register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_reg <= '{dir: RST_PINS, lvl: RST_PINS, lat: RST_PINS,
                  fmask: RST_PINS, rmask: RST_PINS, prev: RST_PINS,
                  prev_ok: 1'b0, oen: ~RST_PINS, irq: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  // Reads are side-effect free; the latch clears only by write
  always_comb begin
    logic [PIN_W-1:0] v;
    v = RST_PINS;
    if (pair_hit(bus.addr, ADR_DIR_SET)) begin
      v = st_reg.dir;
    end else if (pair_hit(bus.addr, ADR_LVL_SET)) begin
      v = st_reg.lvl;
    end else if (bus.addr == ADR_INPUT) begin
      v = GPIO_I; // Live pad level
    end else if (pair_hit(bus.addr, ADR_LAT_SET)) begin
      v = st_reg.lat;
    end else if (pair_hit(bus.addr, ADR_FALL_SET)) begin
      v = st_reg.fmask;
    end else if (pair_hit(bus.addr, ADR_RISE_SET)) begin
      v = st_reg.rmask;
    end
    bus.rdata = {PAD_ZERO, v};
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Level drives pad always; enable decides if it reaches the pin
  assign GPIO_O = st_reg.lvl;
  assign GPIO_OEN_O = st_reg.oen;
  assign IRQ_O = st_reg.irq;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  dir_write_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr == ADR_DIR_SET |=>
    GPIO_OEN_O == ($past(GPIO_OEN_O) & ~$past(bus.wdata[2:0])))
  else $error("direction set did not enable output");

  dir_clear_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr == ADR_DIR_CLR |=>
    GPIO_OEN_O == ($past(GPIO_OEN_O) | $past(bus.wdata[2:0])))
  else $error("direction clear did not make input");

  level_set_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr == ADR_LVL_SET |=>
    GPIO_O == ($past(GPIO_O) | $past(bus.wdata[2:0])))
  else $error("level set wrong");

  level_clear_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr == ADR_LVL_CLR |=>
    GPIO_O == ($past(GPIO_O) & ~$past(bus.wdata[2:0])))
  else $error("level clear wrong");

  input_read_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.addr == ADR_INPUT |-> bus.rdata == {PAD_ZERO, GPIO_I})
  else $error("input read not live pin state");

  input_ro_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && (bus.addr == ADR_INPUT) |=> $stable(st_reg.dir) &&
    $stable(st_reg.lvl) && $stable(st_reg.fmask) && $stable(st_reg.rmask))
  else $error("write to input register changed state");

  latch_clear_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr == ADR_LAT_CLR &&
    ((rise_ev & st_reg.rmask) | (fall_ev & st_reg.fmask)) == RST_PINS
    |=> (st_reg.lat & $past(bus.wdata[2:0])) == RST_PINS)
  else $error("latch clear left a bit set");

  fall_edge_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    (fall_ev & st_reg.fmask) != RST_PINS |=>
    (st_reg.lat & $past(fall_ev & st_reg.fmask)) ==
    $past(fall_ev & st_reg.fmask) && IRQ_O)
  else $error("enabled falling edge not latched");

  rise_edge_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    (rise_ev & st_reg.rmask) != RST_PINS |=>
    (st_reg.lat & $past(rise_ev & st_reg.rmask)) ==
    $past(rise_ev & st_reg.rmask) && IRQ_O)
  else $error("enabled rising edge not latched");

  pair_read_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.addr == ADR_FALL_CLR || bus.addr == ADR_FALL_SET
    |-> bus.rdata == {PAD_ZERO, st_reg.fmask})
  else $error("mask pair read mismatch");

  set_keeps_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr == ADR_RISE_SET |=>
    st_reg.rmask == ($past(st_reg.rmask) | $past(bus.wdata[2:0])))
  else $error("rise mask set disturbed other bits");

  no_cause_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    !bus.wr && ((rise_ev & st_reg.rmask) |
    (fall_ev & st_reg.fmask)) == RST_PINS |=> $stable(st_reg.lat))
  else $error("latch changed without cause");

  irq_level_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    IRQ_O == (|st_reg.lat))
  else $error("interrupt output disagrees with latch");

  upper_zero_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.rdata[7:3] == PAD_ZERO)
  else $error("unused bits read nonzero");

  // Read paths are held against the pins they describe, so a wrong
  // mux leg shows up even when the register itself is right
  dir_read_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.addr == ADR_DIR_SET || bus.addr == ADR_DIR_CLR |->
    bus.rdata == {PAD_ZERO, ~GPIO_OEN_O})
  else $error("direction read disagrees with pad enables");

  level_read_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.addr == ADR_LVL_SET || bus.addr == ADR_LVL_CLR |->
    bus.rdata == {PAD_ZERO, GPIO_O})
  else $error("level read disagrees with pad levels");

  latch_read_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.addr == ADR_LAT_SET || bus.addr == ADR_LAT_CLR |->
    (bus.rdata != 8'h00) == IRQ_O)
  else $error("latch read disagrees with interrupt");

  latch_set_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr == ADR_LAT_SET |=>
    (st_reg.lat & $past(bus.wdata[2:0])) == $past(bus.wdata[2:0]))
  else $error("latch set left a bit clear");

  fall_set_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr == ADR_FALL_SET |=>
    st_reg.fmask == ($past(st_reg.fmask) | $past(bus.wdata[2:0])))
  else $error("fall mask set wrong");

  fall_clear_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr == ADR_FALL_CLR |=>
    st_reg.fmask == ($past(st_reg.fmask) & ~$past(bus.wdata[2:0])))
  else $error("fall mask clear wrong");

  rise_clear_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr == ADR_RISE_CLR |=>
    st_reg.rmask == ($past(st_reg.rmask) & ~$past(bus.wdata[2:0])))
  else $error("rise mask clear wrong");

  level_keep_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    bus.wr && bus.addr != ADR_LVL_SET && bus.addr != ADR_LVL_CLR |=>
    $stable(GPIO_O))
  else $error("pad levels moved on a foreign write");

  unmapped_read_a:
  assert property (@(posedge CLK_I) disable iff (RST_I)
    (bus.addr < ADR_DIR_SET) || (bus.addr > ADR_RISE_CLR) ||
    (bus.addr == (ADR_INPUT | 8'h01)) |-> bus.rdata == 8'h00)
  else $error("unmapped read not zero");

endmodule

// *** test/gsc_host_model.sv ***
// Host model: two-wire serial master that reaches the port's registers.
// Assumes SDA has a pull-up; SCL idles high and moves only inside frames.
`timescale 1ns/1ps

module gsc_host_model
  import gsc_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Serial wires
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oen_o,
  // Read results, one pulse per byte read
  output logic [7:0] res_o,
  output logic res_valid_o
);
  // ----------------------------------------------------------------
  // Bit level, all changes just after a falling clock edge
  // ----------------------------------------------------------------
  initial begin
    scl_o = 1'h1;
    sda_oen_o = 1'h1;
    res_o = 8'h00;
    res_valid_o = 1'h0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // SCL low on entry and exit; phases of 4 cycles keep above the minimum
  task automatic put_bit(input logic b);
    sda_oen_o = b;
    wait_n(2);
    scl_o = 1'h1;
    wait_n(4);
    scl_o = 1'h0;
    wait_n(2);
  endtask

  // Released line reads the pull-up unless the device pulls it down
  task automatic get_bit(output logic b);
    sda_oen_o = 1'h1;
    wait_n(2);
    scl_o = 1'h1;
    wait_n(2);
    b = sda_i;
    wait_n(2);
    scl_o = 1'h0;
    wait_n(2);
  endtask

  // Works from idle and as a repeated start
  task automatic start();
    sda_oen_o = 1'h1;
    wait_n(2);
    scl_o = 1'h1;
    wait_n(4);
    sda_oen_o = 1'h0;
    wait_n(4);
    scl_o = 1'h0;
    wait_n(2);
  endtask

  task automatic stop();
    sda_oen_o = 1'h0;
    wait_n(2);
    scl_o = 1'h1;
    wait_n(4);
    sda_oen_o = 1'h1;
    wait_n(4);
  endtask

  // ----------------------------------------------------------------
  // Byte and register level
  // ----------------------------------------------------------------
  task automatic send_byte(input logic [7:0] b, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(a);
    ok = ok & ~a;
  endtask

  // A refused address byte ends the frame at once
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] data, output logic ok);
    ok = 1'h1;
    start();
    send_byte({dev, 1'h0}, ok);
    if (ok) begin
      send_byte(ptr, ok);
      send_byte(data, ok);
    end
    stop();
  endtask

  // Pointer write, repeated start, n bytes read; NACK on the last
  task automatic read_reg(input logic [7:0] ptr, input int n);
    logic ok;
    logic [7:0] d;
    ok = 1'h1;
    start();
    send_byte({DEV_ADDR, 1'h0}, ok);
    send_byte(ptr, ok);
    start();
    send_byte({DEV_ADDR, 1'h1}, ok);
    for (int j = n; j > 0; j--) begin
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      // Master ACK fetches the next byte, NACK ends the read
      put_bit(j == 1);
      res_o = d;
      res_valid_o = 1'h1;
      wait_n(1);
      res_valid_o = 1'h0;
    end
    stop();
  endtask
endmodule

// *** test/tb_top.sv ***
// Testbench for the set/clear GPIO port, reached over the serial host.
// Assumes pads resolve from enables; external level when released.
`timescale 1ns/1ps

module tb_top import gsc_pkg::*;;
  localparam int LIMIT = 80000; // About three times the expected run
  logic clk;
  logic rst;
  logic scl;
  logic host_oen;
  logic sda_wire;
  logic sda_o;
  logic sda_oen;
  logic [PIN_W-1:0] gpio_o;
  logic [PIN_W-1:0] gpio_oen;
  logic [PIN_W-1:0] ext_pins; // Level of the outside world
  logic [PIN_W-1:0] pads;
  logic irq;
  logic [7:0] res;
  logic res_valid;
  logic [7:0] exp_q[$]; // Expected read bytes, oldest first
  int errors;
  int cmp_count;
  int cyc;
  logic [31:0] seed;
  logic [2:0] m [5]; // Model: dir, level, fall, rise, latch
  logic [7:0] set_a [5] = '{ADR_DIR_SET, ADR_LVL_SET, ADR_FALL_SET,
                            ADR_RISE_SET, ADR_LAT_SET};

  initial clk = 1'h0;
  always #2 clk = ~clk;
  // Open-drain SDA: low when either party pulls it
  assign sda_wire = host_oen & (sda_oen | sda_o);
  assign pads = (gpio_oen & ext_pins) | (~gpio_oen & gpio_o);

  gsc_gpio_port u_dut (.CLK_I(clk), .RST_I(rst), .SCL_I(scl),
    .SDA_I(sda_wire), .SDA_O(sda_o), .SDA_OEN_O(sda_oen), .GPIO_I(pads),
    .GPIO_O(gpio_o), .GPIO_OEN_O(gpio_oen), .IRQ_O(irq));
  gsc_host_model u_host (.clk_i(clk), .sda_i(sda_wire), .scl_o(scl),
    .sda_oen_o(host_oen), .res_o(res), .res_valid_o(res_valid));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.write_reg(DEV_ADDR, a, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask

  // Note the expectation first; the monitor compares when it arrives
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.read_reg(a, 1);
  endtask

  task automatic pins();
    check({5'h00, gpio_oen}, {5'h00, ~m[0]});
    check({5'h00, gpio_o}, {5'h00, m[1]});
    check({7'h00, irq}, {7'h00, |m[4]});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Result watcher; an unexpected byte is compared against a bad value
  always @(posedge clk) begin
    if (res_valid === 1'h1) begin
      check(res, exp_q.size() > 0 ? exp_q.pop_front() : 8'hEE);
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc >= LIMIT) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic ok;
    logic [7:0] v;
    logic [7:0] c;
    rst = 1'h1;
    ext_pins = 3'h0;
    seed = 32'h0000_b49e;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    foreach (m[k]) m[k] = 3'h0;
    repeat (12) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    // Reset state at the pins and at both addresses of each pair
    pins();
    for (int k = 0; k < 5; k++) begin
      rd(set_a[k], 8'h00);
      rd(set_a[k] + 8'h01, 8'h00);
    end
    $display("test reset done");
    // Set, then clear, with random bytes; upper bits must read zero
    repeat (2) begin
      for (int k = 0; k < 5; k++) begin
        v = 8'(rnd());
        c = 8'(rnd());
        wr(set_a[k], v);
        m[k] = m[k] | v[2:0];
        pins();
        rd(set_a[k] + 8'h01, {5'h00, m[k]});
        wr(set_a[k] + 8'h01, c);
        m[k] = m[k] & ~c[2:0];
        pins();
        rd(set_a[k], {5'h00, m[k]});
        wr(set_a[k] + 8'h01, 8'hFF);
        m[k] = 3'h0;
      end
    end
    $display("test set and clear done");
    // Live pad state, with driven outputs seen on their own pads
    repeat (4) begin
      v = 8'(rnd());
      c = 8'(rnd());
      ext_pins = v[6:4];
      wr(ADR_DIR_SET, v);
      wr(ADR_DIR_CLR, ~v);
      m[0] = v[2:0];
      wr(ADR_LVL_SET, c);
      wr(ADR_LVL_CLR, ~c);
      m[1] = c[2:0];
      pins();
      rd(ADR_INPUT, {5'h00, (m[1] & m[0]) | (ext_pins & ~m[0])});
    end
    wr(ADR_DIR_CLR, 8'hFF);
    m[0] = 3'h0;
    rd(8'h19, 8'h00);
    // A write to the input address is ignored
    wr(ADR_INPUT, 8'hFF);
    pins();
    // Burst read: the pointer walks a pair, then reaches the input
    exp_q.push_back({5'h00, m[1]});
    exp_q.push_back({5'h00, m[1]});
    exp_q.push_back({5'h00, ext_pins});
    u_host.read_reg(ADR_LVL_SET, 3);
    // Wrong device address is not acknowledged and changes nothing
    u_host.write_reg(DEV_ADDR ^ 7'h01, ADR_DIR_SET, 8'hFF, ok);
    check({7'h00, ok}, 8'h00);
    pins();
    $display("test input state done");
    // Edge masks: rise on all pins, then fall on all pins
    ext_pins = 3'h0;
    repeat (3) begin
      v = 8'(rnd());
      wr(ADR_FALL_SET, {5'h00, v[2:0]});
      wr(ADR_RISE_SET, {5'h00, v[6:4]});
      ext_pins = 3'h7;
      repeat (4) @(negedge clk);
      m[4] = v[6:4];
      pins();
      ext_pins = 3'h0;
      repeat (4) @(negedge clk);
      m[4] = v[6:4] | v[2:0];
      pins();
      rd(ADR_LAT_SET, {5'h00, m[4]});
      wr(ADR_LAT_CLR, 8'hFF);
      m[4] = 3'h0;
      wr(ADR_FALL_CLR, 8'hFF);
      wr(ADR_RISE_CLR, 8'hFF);
      pins();
    end
    $display("test edge interrupts done");
    repeat (4) @(negedge clk);
    check(8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule
